/* File: verilog/tmr0_pkg.sv */
// package: register map, field layout and mode encodings for the timer core
`default_nettype none
package tmr0_pkg;
    // =========================================================
    // register byte addresses
    localparam logic [7:0] TMR0_OFS_CTRL_A = 8'h00;
    localparam logic [7:0] TMR0_OFS_CTRL_B = 8'h04;
    localparam logic [7:0] TMR0_OFS_COUNT = 8'h08;
    localparam logic [7:0] TMR0_OFS_CMP_A = 8'h0c;
    localparam logic [7:0] TMR0_OFS_CMP_B = 8'h10;
    localparam logic [7:0] TMR0_OFS_MASK = 8'h14;
    localparam logic [7:0] TMR0_OFS_FLAG = 8'h18;
    // =========================================================
    // field positions
    localparam int TMR0_A_WGM0 = 0;
    localparam int TMR0_A_WGM1 = 1;
    localparam int TMR0_A_COMB_LO = 4;
    localparam int TMR0_A_COMA_LO = 6;
    localparam int TMR0_B_CS_LO = 0;
    localparam int TMR0_B_WGM2 = 3;
    localparam int TMR0_B_FOCB = 6;
    localparam int TMR0_B_FOCA = 7;
    localparam int TMR0_F_OVF = 0;
    localparam int TMR0_F_CMPA = 1;
    localparam int TMR0_F_CMPB = 2;
    // =========================================================
    // values
    localparam logic [7:0] TMR0_BOTTOM = 8'h00;
    localparam logic [7:0] TMR0_MAX = 8'hff;
    localparam logic [7:0] TMR0_RST_BYTE = 8'h00;
    localparam logic [1:0] TMR0_RESP_OKAY = 2'h0;
    localparam logic [1:0] TMR0_RESP_SLVERR = 2'h2;
    // clock select codes
    localparam logic [2:0] TMR0_CS_STOP = 3'h0;
    localparam logic [2:0] TMR0_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TMR0_CS_EXT_RISE = 3'h7;
    // waveform modes
    localparam logic [2:0] TMR0_WGM_NORMAL = 3'h0;
    localparam logic [2:0] TMR0_WGM_PC_MAX = 3'h1;
    localparam logic [2:0] TMR0_WGM_CTC = 3'h2;
    localparam logic [2:0] TMR0_WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] TMR0_WGM_PC_OCRA = 3'h5;
    localparam logic [2:0] TMR0_WGM_FAST_OCRA = 3'h7;
endpackage
`default_nettype wire

/* File: verilog/tmr0_core.sv */
// timer0 counter, compare units and AXI4-Lite register slave
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`default_nettype none
module tmr0_core
    import tmr0_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic prescale_tick,
    input wire logic external_count_pin,
    input wire logic [2:0] irq_ack,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] irq_req,
    output logic match_a,
    output logic match_b,
    output logic [2:0] waveform_mode_field,
    output logic [1:0] compare_output_mode_a,
    output logic [1:0] compare_output_mode_b,
    output logic at_max,
    output logic at_bottom,
    output logic compare_output_a,
    output logic compare_output_b
);
    // =========================================================
    // helpers
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m != TMR0_WGM_NORMAL) && (m != TMR0_WGM_CTC);
    endfunction

    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        lane_merge = s[0] ? d[7:0] : old;
    endfunction

    // =========================================================
    // state
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [7:0] timer_count_value_q;
    logic [7:0] compare_value_a_q;
    logic [7:0] compare_value_b_q;
    logic [7:0] cmp_buf_a_q;
    logic [7:0] cmp_buf_b_q;
    logic [2:0] timer_mask_register_q;
    logic [2:0] timer_flag_register_q;
    logic ext_pin_q;
    logic block_q;
    logic dir_down_q;
    logic oc_a_q;
    logic oc_b_q;

    logic [7:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_have_q;

    // =========================================================
    // mode decode
    logic [2:0] wgm;
    logic [2:0] cs;
    logic pwm;
    logic top_is_a;
    logic fast_pwm;
    logic [7:0] top_val;
    logic timer_tick;
    logic is_top;
    logic is_bottom;
    logic cnt_clear;
    logic cnt_count;
    logic cnt_dir_down;
    logic hit_a;
    logic hit_b;
    logic wr_fire;
    logic wr_count;

    assign wgm = {ctrl_b_q[TMR0_B_WGM2], ctrl_a_q[TMR0_A_WGM1], ctrl_a_q[TMR0_A_WGM0]};
    assign cs = ctrl_b_q[TMR0_B_CS_LO +: 3];
    assign pwm = is_pwm(wgm);
    assign top_is_a = wgm[2];
    assign fast_pwm = wgm[0] & wgm[1];
    assign top_val = (top_is_a || wgm == TMR0_WGM_CTC) ? compare_value_a_q : TMR0_MAX;

    // tick source select
    always_comb begin
        case (cs)
            TMR0_CS_STOP: timer_tick = 1'b0;
            TMR0_CS_EXT_FALL: timer_tick = ext_pin_q & ~external_count_pin;
            TMR0_CS_EXT_RISE: timer_tick = ~ext_pin_q & external_count_pin;
            default: timer_tick = prescale_tick;
        endcase
    end

    assign is_top = (timer_count_value_q == top_val);
    assign is_bottom = (timer_count_value_q == TMR0_BOTTOM);
    assign hit_a = (timer_count_value_q == compare_value_a_q) && !block_q;
    assign hit_b = (timer_count_value_q == compare_value_b_q) && !block_q;

    // count, direction and clear controls
    always_comb begin
        cnt_count = timer_tick;
        cnt_clear = 1'b0;
        cnt_dir_down = 1'b0;
        if (wgm == TMR0_WGM_CTC) begin
            cnt_clear = is_top;
        end else if (fast_pwm) begin
            cnt_clear = is_top;
        end else if (wgm[0]) begin
            // phase correct turns round at top and bottom
            if (is_top) begin
                cnt_dir_down = 1'b1;
            end else if (is_bottom) begin
                cnt_dir_down = 1'b0;
            end else begin
                cnt_dir_down = dir_down_q;
            end
        end
    end

    // =========================================================
    // AXI write channel capture
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_count = wr_fire && aw_addr_q == TMR0_OFS_COUNT && w_strb_q[0];

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TMR0_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q > TMR0_OFS_FLAG || aw_addr_q[1:0] != 2'h0)
                ? TMR0_RESP_SLVERR : TMR0_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // =========================================================
    // control and mask registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_a_q <= TMR0_RST_BYTE;
            ctrl_b_q <= TMR0_RST_BYTE;
            timer_mask_register_q <= 3'h0;
        end else begin
            // force strobes read back as zero
            ctrl_b_q[TMR0_B_FOCA] <= 1'b0;
            ctrl_b_q[TMR0_B_FOCB] <= 1'b0;
            if (wr_fire && aw_addr_q == TMR0_OFS_CTRL_A) begin
                ctrl_a_q <= lane_merge(ctrl_a_q, w_data_q, w_strb_q);
            end
            if (wr_fire && aw_addr_q == TMR0_OFS_CTRL_B) begin
                ctrl_b_q <= lane_merge(ctrl_b_q, w_data_q, w_strb_q);
            end
            if (wr_fire && aw_addr_q == TMR0_OFS_MASK && w_strb_q[0]) begin
                timer_mask_register_q <= w_data_q[2:0];
            end
        end
    end

    // =========================================================
    // counter
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_count_value_q <= TMR0_RST_BYTE;
            dir_down_q <= 1'b0;
            ext_pin_q <= 1'b0;
        end else begin
            ext_pin_q <= external_count_pin;
            if (wr_count) begin
                timer_count_value_q <= w_data_q[7:0];
            end else if (cnt_count) begin
                dir_down_q <= cnt_dir_down;
                if (cnt_clear) begin
                    timer_count_value_q <= TMR0_BOTTOM;
                end else if (cnt_dir_down) begin
                    timer_count_value_q <= timer_count_value_q - 8'h01;
                end else begin
                    timer_count_value_q <= timer_count_value_q + 8'h01;
                end
            end
        end
    end

    // match blocking after a count write, held until a tick passes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            block_q <= 1'b0;
        end else if (wr_count) begin
            block_q <= 1'b1;
        end else if (timer_tick) begin
            block_q <= 1'b0;
        end
    end

    // =========================================================
    // compare values and buffers
    logic load_pt;
    assign load_pt = timer_tick && (fast_pwm ? is_top : is_bottom);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            compare_value_a_q <= TMR0_RST_BYTE;
            compare_value_b_q <= TMR0_RST_BYTE;
            cmp_buf_a_q <= TMR0_RST_BYTE;
            cmp_buf_b_q <= TMR0_RST_BYTE;
        end else begin
            if (wr_fire && aw_addr_q == TMR0_OFS_CMP_A && w_strb_q[0]) begin
                if (pwm) begin
                    cmp_buf_a_q <= w_data_q[7:0];
                end else begin
                    compare_value_a_q <= w_data_q[7:0];
                    cmp_buf_a_q <= w_data_q[7:0];
                end
            end
            if (wr_fire && aw_addr_q == TMR0_OFS_CMP_B && w_strb_q[0]) begin
                if (pwm) begin
                    cmp_buf_b_q <= w_data_q[7:0];
                end else begin
                    compare_value_b_q <= w_data_q[7:0];
                    cmp_buf_b_q <= w_data_q[7:0];
                end
            end
            if (pwm && load_pt) begin
                compare_value_a_q <= cmp_buf_a_q;
                compare_value_b_q <= cmp_buf_b_q;
            end
        end
    end

    // =========================================================
    // flags: hardware set wins over clear
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic ovf_evt;

    // overflow when the count wraps from max to zero, at top in fast pwm, or on the tick that leaves bottom after counting down in phase correct
    assign ovf_evt = timer_tick && !wr_count &&
        (pwm && !fast_pwm ? (is_bottom && dir_down_q) :
         (wgm == TMR0_WGM_NORMAL || wgm == TMR0_WGM_CTC) ? (timer_count_value_q == TMR0_MAX)
         : is_top);

    always_comb begin
        flag_set = 3'h0;
        flag_set[TMR0_F_OVF] = ovf_evt;
        flag_set[TMR0_F_CMPA] = timer_tick && hit_a;
        flag_set[TMR0_F_CMPB] = timer_tick && hit_b;
        flag_clr = irq_ack;
        if (wr_fire && aw_addr_q == TMR0_OFS_FLAG && w_strb_q[0]) begin
            flag_clr = flag_clr | w_data_q[2:0];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_flag_register_q <= 3'h0;
        end else begin
            timer_flag_register_q <= (timer_flag_register_q & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req <= 3'h0;
        end else begin
            irq_req <= ((timer_flag_register_q & ~flag_clr) | flag_set)
                & timer_mask_register_q;
        end
    end

    // =========================================================
    // waveform generator interface and simple output register
    logic frc_a;
    logic frc_b;
    assign frc_a = wr_fire && aw_addr_q == TMR0_OFS_CTRL_B && w_strb_q[0]
        && w_data_q[TMR0_B_FOCA] && !pwm;
    assign frc_b = wr_fire && aw_addr_q == TMR0_OFS_CTRL_B && w_strb_q[0]
        && w_data_q[TMR0_B_FOCB] && !pwm;

    function automatic logic oc_next(input logic cur, input logic [1:0] com);
        case (com)
            2'h1: oc_next = ~cur;
            2'h2: oc_next = 1'b0;
            2'h3: oc_next = 1'b1;
            default: oc_next = cur;
        endcase
    endfunction

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oc_a_q <= 1'b0;
            oc_b_q <= 1'b0;
        end else begin
            if (frc_a || (timer_tick && hit_a)) begin
                oc_a_q <= oc_next(oc_a_q, ctrl_a_q[TMR0_A_COMA_LO +: 2]);
            end
            if (frc_b || (timer_tick && hit_b)) begin
                oc_b_q <= oc_next(oc_b_q, ctrl_a_q[TMR0_A_COMB_LO +: 2]);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            match_a <= 1'b0;
            match_b <= 1'b0;
            waveform_mode_field <= 3'h0;
            compare_output_mode_a <= 2'h0;
            compare_output_mode_b <= 2'h0;
            at_max <= 1'b0;
            at_bottom <= 1'b0;
            compare_output_a <= 1'b0;
            compare_output_b <= 1'b0;
        end else begin
            match_a <= hit_a;
            match_b <= hit_b;
            waveform_mode_field <= wgm;
            compare_output_mode_a <= ctrl_a_q[TMR0_A_COMA_LO +: 2];
            compare_output_mode_b <= ctrl_a_q[TMR0_A_COMB_LO +: 2];
            at_max <= (timer_count_value_q == TMR0_MAX);
            at_bottom <= is_bottom;
            compare_output_a <= oc_a_q;
            compare_output_b <= oc_b_q;
        end
    end

    // =========================================================
    // AXI read channel
    logic [7:0] rd_byte;
    always_comb begin
        case (s_axi_araddr)
            TMR0_OFS_CTRL_A: rd_byte = ctrl_a_q;
            TMR0_OFS_CTRL_B: rd_byte = ctrl_b_q;
            TMR0_OFS_COUNT: rd_byte = timer_count_value_q;
            TMR0_OFS_CMP_A: rd_byte = pwm ? cmp_buf_a_q : compare_value_a_q;
            TMR0_OFS_CMP_B: rd_byte = pwm ? cmp_buf_b_q : compare_value_b_q;
            TMR0_OFS_MASK: rd_byte = {5'h00, timer_mask_register_q};
            TMR0_OFS_FLAG: rd_byte = {5'h00, timer_flag_register_q};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TMR0_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= (s_axi_araddr > TMR0_OFS_FLAG || s_axi_araddr[1:0] != 2'h0)
                    ? TMR0_RESP_SLVERR : TMR0_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/tmr0_core_sva.sv */
// checker: bus handshake and counter status assertions for the timer core
`default_nettype none
module tmr0_core_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic at_max,
    input wire logic at_bottom
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // register bus
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed");
    a_no_new_write: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while pending");
    a_bresp_legal: assert property (
        s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("illegal write response");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    // ==========================================
    // counter status
    a_ends_apart: assert property (
        !(at_max && at_bottom))
        else $error("max and bottom together");
endmodule
bind tmr0_core tmr0_core_chk u_chk (.sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .at_max, .at_bottom);
`default_nettype wire

/* File: tb/tmr0_core_tb_top.sv */
// testbench: register access and counting scenarios for the timer core
`default_nettype none
module tmr0_core_tb_top import tmr0_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, sys_rst, prescale_tick, external_count_pin;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic match_a, match_b, at_max, at_bottom, compare_output_a, compare_output_b;
    logic [1:0] s_axi_bresp, s_axi_rresp, compare_output_mode_a, compare_output_mode_b;
    logic [2:0] irq_ack, irq_req, waveform_mode_field;
    logic [3:0] s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int n_mismatch, total_checks;
    tmr0_core u_dut (.sys_clk, .sys_rst, .prescale_tick, .external_count_pin, .irq_ack,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_req, .match_a, .match_b, .waveform_mode_field,
        .compare_output_mode_a, .compare_output_mode_b, .at_max, .at_bottom,
        .compare_output_a, .compare_output_b);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // ==========================================
    // checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic hang(input logic got);
        if (!got) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    // ==========================================
    // bus cycles and ticks
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er = TMR0_RESP_OKAY, input logic [3:0] s = 4'h1);
        int n;
        logic got;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            got = s_axi_bvalid;
        end while (!got && n < 200);
        s_axi_bready <= 1'b0;
        hang(got);
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
            input logic [1:0] er = TMR0_RESP_OKAY);
        int n;
        logic got;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            got = s_axi_rvalid;
        end while (!got && n < 200);
        s_axi_rready <= 1'b0;
        hang(got);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    // prescaler strobe driven to level p for one cycle, and the count pin left at level e
    task automatic pulse(input logic p, input logic e);
        @(posedge sys_clk);
        prescale_tick <= p;
        external_count_pin <= e;
        @(posedge sys_clk);
        prescale_tick <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    // ==========================================
    // scenarios
    initial begin
        sys_rst = 1'b1;
        {prescale_tick, external_count_pin, irq_ack, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
        rd(8'h1c, 32'h0, TMR0_RESP_SLVERR);
        wr(8'h09, 32'h5, TMR0_RESP_SLVERR);
        wr(TMR0_OFS_COUNT, 32'h1ab);
        rd(TMR0_OFS_COUNT, 32'hab);
        wr(TMR0_OFS_COUNT, 32'h11, TMR0_RESP_OKAY, 4'he);
        rd(TMR0_OFS_COUNT, 32'hab);
        for (int cs = 0; cs < 8; cs++) begin
            wr(TMR0_OFS_CTRL_B, 32'(cs));
            wr(TMR0_OFS_COUNT, 32'h0);
            pulse(1'b1, 1'b0);
            pulse(1'b0, 1'b1);
            rd(TMR0_OFS_COUNT, (cs == 0 || cs == 6) ? 32'h0 : 32'h1);
            pulse(1'b0, 1'b0);
            rd(TMR0_OFS_COUNT, (cs == 0) ? 32'h0 : 32'h1);
        end
        wr(TMR0_OFS_CTRL_B, 32'h1);
        wr(TMR0_OFS_MASK, 32'h7);
        rd(TMR0_OFS_MASK, 32'h7);
        wr(TMR0_OFS_COUNT, 32'hfe);
        pulse(1'b1, 1'b0);
        chk(32'(at_max), 32'h1);
        rd(TMR0_OFS_FLAG, 32'h0);
        pulse(1'b1, 1'b0);
        chk(32'(at_bottom), 32'h1);
        chk(32'(irq_req), 32'h1);
        rd(TMR0_OFS_FLAG, 32'h1);
        wr(TMR0_OFS_MASK, 32'h6);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq_req), 32'h0);
        wr(TMR0_OFS_FLAG, 32'h1);
        rd(TMR0_OFS_FLAG, 32'h0);
        wr(TMR0_OFS_CMP_A, 32'h10);
        wr(TMR0_OFS_COUNT, 32'h10);
        pulse(1'b1, 1'b0);
        rd(TMR0_OFS_FLAG, 32'h0);
        wr(TMR0_OFS_COUNT, 32'h0e);
        pulse(1'b1, 1'b0);
        pulse(1'b1, 1'b0);
        chk(32'(match_a), 32'h1);
        rd(TMR0_OFS_FLAG, 32'h0);
        pulse(1'b1, 1'b0);
        rd(TMR0_OFS_FLAG, 32'h2);
        chk(32'(irq_req), 32'h2);
        irq_ack <= 3'h2;
        @(posedge sys_clk);
        irq_ack <= 3'h0;
        rd(TMR0_OFS_FLAG, 32'h0);
        // clear on match with output toggle on unit a
        wr(TMR0_OFS_CTRL_A, 32'h42);
        wr(TMR0_OFS_CMP_A, 32'h03);
        wr(TMR0_OFS_CMP_B, 32'h02);
        wr(TMR0_OFS_COUNT, 32'h00);
        repeat (4) pulse(1'b1, 1'b0);
        rd(TMR0_OFS_COUNT, 32'h0);
        rd(TMR0_OFS_FLAG, 32'h6);
        chk(32'(waveform_mode_field), 32'(TMR0_WGM_CTC));
        chk(32'(compare_output_mode_a), 32'h1);
        chk(32'(compare_output_a), 32'h1);
        chk(32'(compare_output_mode_b), 32'h0);
        chk(32'(compare_output_b), 32'h0);
        chk(32'(match_b), 32'h0);
        wr(TMR0_OFS_FLAG, 32'h7);
        wr(TMR0_OFS_CTRL_B, 32'h81);
        repeat (2) @(posedge sys_clk);
        chk(32'(compare_output_a), 32'h0);
        rd(TMR0_OFS_CTRL_B, 32'h1);
        rd(TMR0_OFS_FLAG, 32'h0);
        rd(TMR0_OFS_COUNT, 32'h0);
        // buffered against direct compare writes
        wr(TMR0_OFS_CTRL_A, 32'h03);
        wr(TMR0_OFS_COUNT, 32'h20);
        wr(TMR0_OFS_CMP_A, 32'h21);
        rd(TMR0_OFS_CMP_A, 32'h21);
        pulse(1'b1, 1'b0);
        chk(32'(match_a), 32'h0);
        wr(TMR0_OFS_CTRL_A, 32'h00);
        wr(TMR0_OFS_CMP_A, 32'h21);
        repeat (2) @(posedge sys_clk);
        chk(32'(match_a), 32'h1);
        // reset in mid-run
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(TMR0_OFS_COUNT, 32'h0);
        rd(TMR0_OFS_CMP_A, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
